// File: include/acb_pkg.sv
package acb_pkg;
    // ----------------------------------------
    // io transfer instruction decode
    // ----------------------------------------
    localparam logic [5:0] DEV_CODE = 6'h0b;
    localparam logic [1:0] SUB_DATA = 2'h0;
    localparam logic [1:0] SUB_CTRL = 2'h1;
    localparam int TP_SKIP = 0;
    localparam int TP_READ = 1;
    localparam int TP_WRITE = 2;
    // ----------------------------------------
    // control word fields
    // ----------------------------------------
    localparam int CW_CHAN_LSB = 0;
    localparam int CW_GAIN_LSB = 7;
    localparam int CW_EXT_SYNC = 9;
    localparam int CW_DCH = 10;
    localparam int CW_SEQ = 11;
    localparam int CW_ADD_MEM = 12;
    localparam int CW_PI_EN = 13;
    localparam int CW_API_EN = 14;
    localparam int CW_RUN = 15;
    localparam int CW_W = 18;
    // ----------------------------------------
    // status word fields
    // ----------------------------------------
    localparam int SW_DONE = 7;
    localparam int SW_BUSY = 8;
    localparam int SW_DCH_REQ = 9;
    // ----------------------------------------
    // wishbone register byte offsets
    // ----------------------------------------
    localparam logic [5:0] REG_CTRL = 6'h00;
    localparam logic [5:0] REG_STATUS = 6'h04;
    localparam logic [5:0] REG_RESULT = 6'h08;
    localparam logic [5:0] REG_IRQ_STAT = 6'h0c;
    localparam logic [5:0] REG_IRQ_MASK = 6'h10;
    localparam logic [5:0] REG_SEQ_LAST = 6'h14;
    localparam logic [5:0] REG_TABLE = 6'h20;
    localparam logic [17:0] CTRL_RESET = 18'h00000;
    localparam logic [6:0] SEQ_LAST_RESET = 7'h7f;
    // interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_XFER = 1;
    localparam int IRQ_OVERRUN = 2;
    localparam int IRQ_W = 3;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_MHZ = 10;
    localparam int CONV_PERIOD_US = 40;
    localparam int CONV_PERIOD_CYC = CONV_PERIOD_US * CLK_MHZ;
    typedef enum logic [1:0] {ACB_IDLE, ACB_START, ACB_WAIT, ACB_XFER} acb_state_type;
endpackage

// File: core/acb_tick_div.sv
`timescale 1ns/10ps
module acb_tick_div #(
    parameter int PERIOD = 400
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    output logic tick_o
);
    localparam int CW = $clog2(PERIOD + 1);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
    logic [CW-1:0] cnt_r;

    // refused while elaborating, before any count runs
    if (PERIOD < 2) begin : g_bad_period
        $error("acb_tick_div: PERIOD below 2");
    end

    // free count while enabled, restarts when disabled
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_i) begin
            cnt_r <= '0;
            tick_o <= 1'b0;
        end else begin
            tick_o <= (cnt_r == LAST);
            cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
        end
    end
endmodule // acb_tick_div

// File: core/acb_core.sv
`timescale 1ns/10ps
module acb_core #(
    parameter int TABLE_DEPTH = 8,
    parameter int CONV_PERIOD = acb_pkg::CONV_PERIOD_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic io_transfer_instruction_i,
    input wire logic [5:0] io_dev_sel_i,
    input wire logic [1:0] io_subdev_i,
    input wire logic [2:0] io_timing_pulse_i,
    input wire logic [17:0] io_data_i,
    output logic [17:0] io_data_o,
    output logic io_data_oe_o,
    output logic io_skip_o,
    output logic program_interrupt_request_o,
    output logic priority_interrupt_request_o,
    output logic direct_channel_transfer_o,
    input wire logic dch_grant_i,
    output logic dch_add_to_mem_o,
    output logic conv_start_o,
    input wire logic conv_done_i,
    input wire logic [12:0] conv_result_i,
    input wire logic ext_sync_i,
    output logic [6:0] mux_channel_o,
    output logic [1:0] gain_sel_o,
    output logic irq_o
);
    localparam int TW = $clog2(TABLE_DEPTH);

    // refuse depths that the index slice cannot address
    if (TABLE_DEPTH < 2 || TABLE_DEPTH > 8 || (1 << TW) != TABLE_DEPTH) begin : g_bad_depth
        $error("acb_core: TABLE_DEPTH must be 2, 4 or 8");
    end

    acb_pkg::acb_state_type state_r;
    logic [17:0] ctrl_r;
    logic [17:0] result_r;
    logic done_r;
    logic [6:0] seq_last_r;
    logic [6:0] table_r [TABLE_DEPTH];
    logic [TW-1:0] tidx_r;
    logic [acb_pkg::IRQ_W-1:0] irq_stat_r;
    logic [acb_pkg::IRQ_W-1:0] irq_mask_r;
    logic ext_sync_q_r;
    logic tick;

    // ----------------------------------------
    // instruction decode
    // ----------------------------------------
    // device code match
    logic hit;
    assign hit = io_transfer_instruction_i && io_dev_sel_i == acb_pkg::DEV_CODE;
    logic skip_tp, rd_res, rd_stat, clr_done, wr_ctrl, sw_start;
    assign skip_tp = hit && io_timing_pulse_i[acb_pkg::TP_SKIP]
                     && io_subdev_i == acb_pkg::SUB_DATA;
    assign clr_done = hit && io_timing_pulse_i[acb_pkg::TP_SKIP]
                      && io_subdev_i == acb_pkg::SUB_CTRL;
    assign rd_res = hit && io_timing_pulse_i[acb_pkg::TP_READ]
                    && io_subdev_i == acb_pkg::SUB_DATA;
    assign rd_stat = hit && io_timing_pulse_i[acb_pkg::TP_READ]
                     && io_subdev_i == acb_pkg::SUB_CTRL;
    assign wr_ctrl = hit && io_timing_pulse_i[acb_pkg::TP_WRITE]
                     && io_subdev_i == acb_pkg::SUB_DATA;
    assign sw_start = hit && io_timing_pulse_i[acb_pkg::TP_WRITE]
                      && io_subdev_i == acb_pkg::SUB_CTRL;

    // ----------------------------------------
    // wishbone slave
    // ----------------------------------------
    logic wb_req, wb_wr;
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
    logic [17:0] status_word;
    assign status_word = {8'h00, direct_channel_transfer_o, state_r != acb_pkg::ACB_IDLE,
                          done_r, mux_channel_o};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h00000000;
            if (wb_req && !wb_we_i) begin
                if (wb_adr_i >= acb_pkg::REG_TABLE) begin
                    wb_dat_o <= {25'h0000000, table_r[wb_adr_i[TW+1:2]]};
                end else begin
                    unique case (wb_adr_i)
                        acb_pkg::REG_CTRL: wb_dat_o <= {14'h0000, ctrl_r};
                        acb_pkg::REG_STATUS: wb_dat_o <= {14'h0000, status_word};
                        acb_pkg::REG_RESULT: wb_dat_o <= {14'h0000, result_r};
                        acb_pkg::REG_IRQ_STAT: wb_dat_o <= {29'h00000000, irq_stat_r};
                        acb_pkg::REG_IRQ_MASK: wb_dat_o <= {29'h00000000, irq_mask_r};
                        acb_pkg::REG_SEQ_LAST: wb_dat_o <= {25'h0000000, seq_last_r};
                        default: wb_dat_o <= 32'h00000000;
                    endcase
                end
            end
        end
    end

    // table above the decoded registers; a depth below 8 repeats through the mapped window
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < TABLE_DEPTH; i++) table_r[i] <= 7'h00;
            seq_last_r <= acb_pkg::SEQ_LAST_RESET;
            irq_mask_r <= '0;
        end else if (wb_wr) begin
            if (wb_adr_i >= acb_pkg::REG_TABLE)
                table_r[wb_adr_i[TW+1:2]] <= wb_dat_i[6:0];
            if (wb_adr_i == acb_pkg::REG_SEQ_LAST) seq_last_r <= wb_dat_i[6:0];
            if (wb_adr_i == acb_pkg::REG_IRQ_MASK) irq_mask_r <= wb_dat_i[acb_pkg::IRQ_W-1:0];
        end
    end

    // ----------------------------------------
    // control word
    // ----------------------------------------
    logic dch_mode, seq_mode, run;
    assign dch_mode = ctrl_r[acb_pkg::CW_DCH];
    assign seq_mode = ctrl_r[acb_pkg::CW_SEQ];
    assign run = ctrl_r[acb_pkg::CW_RUN];
    logic advance;
    assign advance = state_r == acb_pkg::ACB_XFER && dch_grant_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= acb_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= io_data_i;
        end else if (wb_wr && wb_adr_i == acb_pkg::REG_CTRL) begin
            ctrl_r <= wb_dat_i[acb_pkg::CW_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mux_channel_o <= 7'h00;
            tidx_r <= '0;
        end else if (wr_ctrl) begin
            mux_channel_o <= io_data_i[acb_pkg::CW_CHAN_LSB +: 7];
            tidx_r <= '0;
        end else if (wb_wr && wb_adr_i == acb_pkg::REG_CTRL) begin
            // a register-bus control word selects the channel as well
            mux_channel_o <= wb_dat_i[acb_pkg::CW_CHAN_LSB +: 7];
            tidx_r <= '0;
        end else if (advance && seq_mode) begin
            mux_channel_o <= (mux_channel_o == seq_last_r) ? 7'h00 : mux_channel_o + 7'h01;
        end else if (advance) begin
            mux_channel_o <= table_r[tidx_r + 1'b1];
            tidx_r <= tidx_r + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) gain_sel_o <= 2'h0;
        else gain_sel_o <= ctrl_r[acb_pkg::CW_GAIN_LSB +: 2];
    end

    // ----------------------------------------
    // conversion start
    // ----------------------------------------
    // internal pacing timer
    acb_tick_div #(
        .PERIOD(CONV_PERIOD)
    ) u_pace (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(run && !ctrl_r[acb_pkg::CW_EXT_SYNC]),
        .tick_o(tick)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) ext_sync_q_r <= 1'b0;
        else ext_sync_q_r <= ext_sync_i;
    end

    logic sync_ev;
    assign sync_ev = ctrl_r[acb_pkg::CW_EXT_SYNC] ? (ext_sync_i && !ext_sync_q_r) : tick;
    logic start_req;
    assign start_req = sw_start || (run && sync_ev);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= acb_pkg::ACB_IDLE;
            conv_start_o <= 1'b0;
        end else begin
            conv_start_o <= 1'b0;
            unique case (state_r)
                acb_pkg::ACB_IDLE: if (start_req) begin
                    state_r <= acb_pkg::ACB_START;
                    conv_start_o <= 1'b1;
                end
                acb_pkg::ACB_START: state_r <= acb_pkg::ACB_WAIT;
                acb_pkg::ACB_WAIT: if (conv_done_i) begin
                    // channel mode goes to memory, program mode stops
                    state_r <= dch_mode ? acb_pkg::ACB_XFER : acb_pkg::ACB_IDLE;
                end
                acb_pkg::ACB_XFER: if (dch_grant_i) state_r <= acb_pkg::ACB_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) result_r <= 18'h00000;
        else if (state_r == acb_pkg::ACB_WAIT && conv_done_i)
            result_r <= {{5{conv_result_i[12]}}, conv_result_i};
    end

    // done flag, set wins over clear
    logic done_set;
    assign done_set = state_r == acb_pkg::ACB_WAIT && conv_done_i;
    always_ff @(posedge clk_i) begin
        if (rst_i) done_r <= 1'b0;
        else if (done_set) done_r <= 1'b1;
        else if (rd_res || clr_done || advance) done_r <= 1'b0;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            direct_channel_transfer_o <= 1'b0;
            dch_add_to_mem_o <= 1'b0;
        end else begin
            direct_channel_transfer_o <= (done_set && dch_mode)
                || (direct_channel_transfer_o && !dch_grant_i);
            dch_add_to_mem_o <= (done_set && dch_mode) ? ctrl_r[acb_pkg::CW_ADD_MEM]
                : (dch_add_to_mem_o && !dch_grant_i);
        end
    end

    // ----------------------------------------
    // host data bus and skip
    // ----------------------------------------
    // result or status onto the bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            io_data_o <= 18'h00000;
            io_data_oe_o <= 1'b0;
            io_skip_o <= 1'b0;
        end else begin
            io_data_oe_o <= rd_res || rd_stat || advance;
            io_data_o <= rd_stat ? status_word : result_r;
            io_skip_o <= skip_tp && done_r;
        end
    end

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    // program and priority requests
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            program_interrupt_request_o <= 1'b0;
            priority_interrupt_request_o <= 1'b0;
        end else begin
            program_interrupt_request_o <= done_r && ctrl_r[acb_pkg::CW_PI_EN];
            priority_interrupt_request_o <= done_r && ctrl_r[acb_pkg::CW_API_EN];
        end
    end

    // sticky events; set beats a write-one clear in the same cycle
    logic [acb_pkg::IRQ_W-1:0] ev, w1c;
    assign ev = {start_req && state_r != acb_pkg::ACB_IDLE, advance, done_set};
    assign w1c = (wb_wr && wb_adr_i == acb_pkg::REG_IRQ_STAT) ?
                 wb_dat_i[acb_pkg::IRQ_W-1:0] : '0;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_r <= '0;
            irq_o <= 1'b0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~w1c) | ev;
            irq_o <= |(irq_stat_r & irq_mask_r);
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_start;
        conv_start_o;
    endsequence
    sequence s_quiet;
        !conv_start_o [*2];
    endsequence

    dev_code_a: assert property (io_data_oe_o && !$past(advance) |->
        $past(hit)) else $error("bus driven without device code");
    skip_done_a: assert property (io_skip_o |-> $past(done_r))
        else $error("skip without done");
    start_pulse_a: assert property (s_start |=> s_quiet)
        else $error("start pulse too long");
    done_set_a: assert property (done_set |=> done_r && result_r[12:0] == $past(conv_result_i))
        else $error("completion not captured");
    sign_ext_a: assert property (done_set |=>
        result_r == {{5{$past(conv_result_i[12])}}, $past(conv_result_i)})
        else $error("result not sign extended");
    pi_req_a: assert property (done_r && ctrl_r[acb_pkg::CW_PI_EN] [*2] |->
        program_interrupt_request_o) else $error("program interrupt missing");
    dch_hold_a: assert property (direct_channel_transfer_o && !dch_grant_i |=>
        direct_channel_transfer_o) else $error("steal request dropped");
    chan_load_a: assert property (wr_ctrl |=> mux_channel_o == $past(io_data_i[6:0]))
        else $error("channel not loaded");
    ctrl_load_a: assert property (wr_ctrl |=> ctrl_r == $past(io_data_i))
        else $error("control word not loaded");
    irq_mask_a: assert property (irq_o |-> $past(|(irq_stat_r & irq_mask_r)))
        else $error("interrupt without cause");
endmodule // acb_core

// File: dv/acb_far_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// converter and io processor stand-in
// ----------------------------------------
module acb_far_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic req_i,
    input wire logic oe_i,
    input wire logic [17:0] data_i,
    input wire logic [6:0] chan_i,
    input wire logic [12:0] res_i,
    output logic done_o,
    output logic [12:0] result_o,
    output logic grant_o,
    output int n_start_o,
    output int n_done_o,
    output int n_xfer_o,
    output logic [17:0] word_o,
    output logic [6:0] chan_o
);
    int cnt;
    int gcnt;
    logic hold;
    initial {done_o, grant_o} = 2'b00;
    // off-pulse result lines show the inverse so a stale copy is never mistaken
    assign result_o = done_o ? res_i : ~res_i;
    // done after start, alternately prompt and slow
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            cnt <= 0;
            n_start_o <= 0;
            n_done_o <= 0;
        end else if (start_i) begin
            n_start_o <= n_start_o + 1;
            cnt <= n_start_o[0] ? 6 : 2;
        end else if (cnt == 1) begin
            done_o <= 1'b1;
            n_done_o <= n_done_o + 1;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
    // alternately prompt and stalled, one grant per request
    always @(posedge clk_i) begin
        grant_o <= 1'b0;
        if (rst_i) begin
            gcnt <= 0;
            hold <= 1'b0;
            n_xfer_o <= 0;
            word_o <= 18'h0;
            chan_o <= 7'h0;
        end else begin
            if (req_i && !hold) begin
                gcnt <= gcnt + 1;
                if (gcnt == (n_xfer_o[0] ? 3 : 0)) begin
                    grant_o <= 1'b1;
                    hold <= 1'b1;
                    gcnt <= 0;
                end
            end
            if (oe_i && hold) begin
                word_o <= data_i;
                chan_o <= chan_i;
                n_xfer_o <= n_xfer_o + 1;
                hold <= 1'b0;
            end
        end
    end
endmodule // acb_far_model

// File: dv/testbench.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [5:0] wb_adr_i = 6'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, r;
    logic io_transfer_instruction_i = 1'b0, ext_sync_i = 1'b0;
    logic [5:0] io_dev_sel_i = 6'h00;
    logic [1:0] io_subdev_i = 2'h0, gain_sel_o;
    logic [2:0] io_timing_pulse_i = 3'h0;
    logic [17:0] io_data_i = 18'h0, io_data_o, iod, xw, cw;
    logic [12:0] res = 13'h0, conv_result_i;
    logic [6:0] mux_channel_o, xc, c, tb [8];
    logic wb_ack_o, io_data_oe_o, io_skip_o, program_interrupt_request_o;
    logic priority_interrupt_request_o, direct_channel_transfer_o, dch_add_to_mem_o;
    logic conv_start_o, conv_done_i, dch_grant_i, irq_o, oe, sk;
    logic [31:0] seed = 32'h00006560;
    int n_mismatch = 0, comparisons = 0, n_start, n_done, n_xfer, i, j, nd;
    // pacing period long enough that every conversion and steal ends before the next tick
    localparam int PACE = 16;

    always #50 clk_i = ~clk_i;

    acb_core #(.TABLE_DEPTH(8), .CONV_PERIOD(PACE)) DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .io_transfer_instruction_i, .io_dev_sel_i, .io_subdev_i, .io_timing_pulse_i,
        .io_data_i, .io_data_o, .io_data_oe_o, .io_skip_o, .program_interrupt_request_o,
        .priority_interrupt_request_o, .direct_channel_transfer_o, .dch_grant_i,
        .dch_add_to_mem_o, .conv_start_o, .conv_done_i, .conv_result_i, .ext_sync_i,
        .mux_channel_o, .gain_sel_o, .irq_o);
    acb_far_model far (.clk_i, .rst_i, .start_i(conv_start_o), .req_i(direct_channel_transfer_o),
        .oe_i(io_data_oe_o), .data_i(io_data_o), .chan_i(mux_channel_o), .res_i(res),
        .done_o(conv_done_i), .result_o(conv_result_i), .grant_o(dch_grant_i),
        .n_start_o(n_start), .n_done_o(n_done), .n_xfer_o(n_xfer), .word_o(xw), .chan_o(xc));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [17:0] sx(input logic [12:0] v);
        return {{5{v[12]}}, v};
    endfunction
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
        int k;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, w, 4'hf};
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (k = 0; k < 20 && wb_ack_o !== 1'b1; k++) @(posedge clk_i);
        if (k == 20) begin n_mismatch++; finish_test(); end
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask
    // device, subdevice and one timing pulse together for one cycle
    task automatic io(input logic [1:0] s, input logic [2:0] p, input logic [5:0] dv,
            input logic [17:0] d);
        {io_transfer_instruction_i, io_dev_sel_i, io_subdev_i} <= {1'b1, dv, s};
        io_timing_pulse_i <= p;
        io_data_i <= d;
        @(posedge clk_i);
        io_transfer_instruction_i <= 1'b0;
        io_timing_pulse_i <= 3'h0;
        @(posedge clk_i);
        {oe, iod, sk} = {io_data_oe_o, io_data_o, io_skip_o};
    endtask
    task automatic waitc(input int sel, input int v);
        int k;
        for (k = 0; k < 200 && v == (sel == 0 ? n_done : sel == 1 ? n_xfer : n_start); k++)
            @(posedge clk_i);
        if (k == 200) begin n_mismatch++; finish_test(); end
    endtask
    task automatic dch_step(input logic add);
        int k;
        int m;
        m = n_xfer;
        for (k = 0; k < 100 && direct_channel_transfer_o !== 1'b1; k++) @(posedge clk_i);
        if (k == 100) begin n_mismatch++; finish_test(); end
        `CHK("dch req", 1'b1, direct_channel_transfer_o)
        `CHK("add mem", add, dch_add_to_mem_o)
        waitc(1, m);
        `CHK("dch word", sx(res), xw)
    endtask
    // cycles from one paced start pulse to the next
    task automatic pace_chk();
        int k;
        for (k = 0; k < 100 && conv_start_o !== 1'b1; k++) @(posedge clk_i);
        @(posedge clk_i);
        for (k = 1; k < 100 && conv_start_o !== 1'b1; k++) @(posedge clk_i);
        if (k == 100) begin n_mismatch++; finish_test(); end
        `CHK("pace", PACE, k)
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, acb_pkg::REG_CTRL, 32'h0);
        `CHK("ctrl rst", 32'h0, rd)
        wb(1'b1, acb_pkg::REG_CTRL, 32'h00000105);
        wb(1'b0, acb_pkg::REG_CTRL, 32'h0);
        `CHK("ctrl wb", 32'h105, rd)
        `CHK("chan wb", 7'h05, mux_channel_o)
        `CHK("gain wb", 2'h2, gain_sel_o)
        wb(1'b0, acb_pkg::REG_SEQ_LAST, 32'h0);
        `CHK("seq last rst", 32'h7f, rd)
        wb(1'b0, 6'h18, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            r = rnd();
            cw = {9'h0, 2'(i), r[6:0]};
            io(acb_pkg::SUB_DATA, 3'h4, acb_pkg::DEV_CODE, cw);
            @(posedge clk_i);
            `CHK("chan", r[6:0], mux_channel_o)
            `CHK("gain", 2'(i), gain_sel_o)
        end
        io(acb_pkg::SUB_DATA, 3'h4, 6'h0a, ~cw);
        @(posedge clk_i);
        `CHK("other dev", cw[6:0], mux_channel_o)
        io(acb_pkg::SUB_DATA, 3'h2, 6'h0c, 18'h0);
        `CHK("other dev oe", 1'b0, oe)
        $display("test control word done");
        for (i = 0; i < 4; i++) begin
            r = rnd();
            res = (i == 0) ? 13'h1000 : (i == 1) ? 13'h0fff : r[12:0];
            c = r[19:13];
            cw = {11'h0, c} | (18'h1 << (i[0] ? acb_pkg::CW_PI_EN : acb_pkg::CW_API_EN));
            wb(1'b1, acb_pkg::REG_IRQ_MASK, {31'h0, i[1]});
            io(acb_pkg::SUB_DATA, 3'h4, acb_pkg::DEV_CODE, cw);
            nd = n_done;
            io(acb_pkg::SUB_CTRL, 3'h4, acb_pkg::DEV_CODE, 18'h0);
            io(acb_pkg::SUB_CTRL, 3'h4, acb_pkg::DEV_CODE, 18'h0);
            waitc(0, nd);
            io(acb_pkg::SUB_DATA, 3'h1, acb_pkg::DEV_CODE, 18'h0);
            `CHK("skip", 1'b1, sk)
            `CHK("pi api", {i[0], ~i[0]}, {program_interrupt_request_o, priority_interrupt_request_o})
            `CHK("irq", i[1], irq_o)
            io(acb_pkg::SUB_CTRL, 3'h2, acb_pkg::DEV_CODE, 18'h0);
            `CHK("status", {11'h1, c}, iod)
            io(acb_pkg::SUB_DATA, 3'h2, acb_pkg::DEV_CODE, 18'h0);
            `CHK("result oe", 1'b1, oe)
            `CHK("result", sx(res), iod)
            io(acb_pkg::SUB_DATA, 3'h1, acb_pkg::DEV_CODE, 18'h0);
            `CHK("skip clr", 1'b0, sk)
            wb(1'b0, acb_pkg::REG_IRQ_STAT, 32'h0);
            `CHK("irq stat", 32'h5, rd)
            wb(1'b1, acb_pkg::REG_IRQ_STAT, 32'h7);
            wb(1'b0, acb_pkg::REG_IRQ_STAT, 32'h0);
            `CHK("irq w1c", 32'h0, rd)
            `CHK("irq low", 1'b0, irq_o)
        end
        $display("test program transfer done");
        wb(1'b1, acb_pkg::REG_SEQ_LAST, 32'h3);
        r = rnd();
        res = r[12:0];
        cw = 18'h2 | (18'h1 << acb_pkg::CW_DCH) | (18'h1 << acb_pkg::CW_SEQ);
        cw = cw | (18'h1 << acb_pkg::CW_ADD_MEM) | (18'h1 << acb_pkg::CW_RUN);
        c = 7'h2;
        io(acb_pkg::SUB_DATA, 3'h4, acb_pkg::DEV_CODE, cw);
        for (j = 0; j < 4; j++) begin
            dch_step(1'b1);
            c = (c == 7'h3) ? 7'h0 : c + 7'h1;
            `CHK("seq chan", c, xc)
        end
        pace_chk();
        io(acb_pkg::SUB_DATA, 3'h4, acb_pkg::DEV_CODE, 18'h0);
        repeat (40) @(posedge clk_i);
        io(acb_pkg::SUB_CTRL, 3'h1, acb_pkg::DEV_CODE, 18'h0);
        for (j = 0; j < 8; j++) begin
            r = rnd();
            tb[j] = r[6:0];
            wb(1'b1, acb_pkg::REG_TABLE + 6'(4 * j), {25'h0, tb[j]});
        end
        cw = {11'h0, tb[0]} | (18'h1 << acb_pkg::CW_DCH) | (18'h1 << acb_pkg::CW_RUN);
        io(acb_pkg::SUB_DATA, 3'h4, acb_pkg::DEV_CODE, cw);
        for (j = 0; j < 3; j++) begin
            dch_step(1'b0);
            `CHK("table chan", tb[j + 1], xc)
        end
        io(acb_pkg::SUB_DATA, 3'h4, acb_pkg::DEV_CODE, 18'h0);
        repeat (40) @(posedge clk_i);
        $display("test data channel done");
        cw = 18'h5 | (18'h1 << acb_pkg::CW_EXT_SYNC) | (18'h1 << acb_pkg::CW_RUN);
        io(acb_pkg::SUB_DATA, 3'h4, acb_pkg::DEV_CODE, cw);
        nd = n_start;
        repeat (20) @(posedge clk_i);
        `CHK("no sync", nd, n_start)
        ext_sync_i <= 1'b1;
        waitc(2, nd);
        ext_sync_i <= 1'b0;
        `CHK("sync start", nd + 1, n_start)
        $display("test external sync done");
        finish_test();
    end
endmodule // testbench
